// ---- common/uoe_regs.svh ----
// register offsets, field positions and reset values for the out endpoint
// ****************************************************************
// Overview of operation
// ****************************************************************
// Overview of operation
// - writing one to the set-nak strobe sets the nak status flag
// - writing one to the clear-nak strobe clears the nak status flag
// - while stall is set, out transactions get a stall handshake
// - stall wins over nak status and global out nak
// - control endpoint: setup token clears stall; software cannot clear
// - bulk or interrupt endpoint: only software clears stall
// - snoop mode accepts out data without a crc check
// - type field: 00 control, 01 iso, 10 bulk, 11 interrupt
// - otherwise nak status 1 gives nak, else the rx fifo state decides
// - nak status is read-only; only strobes or the device change it
// - iso endpoint drops data when frame parity mismatches the select bit
// - with endpoint active clear, tokens are ignored with no response
// - eleven-bit field holds the max packet length in bytes
// - enable bit set by software, cleared by the device
// - odd-frame strobe sets frame parity, even-frame strobe clears it
// - force-data0 strobe clears data pid, force-data1 strobe sets it
`ifndef UOE_REGS_SVH
`define UOE_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define UOE_CTL_OFFSET 4'h0
`define UOE_CTL_RESET 32'h00000000

// ****************************************************************
// field positions
// ****************************************************************
`define UOE_ENABLE_BIT 31
`define UOE_DISABLE_BIT 30
`define UOE_ODD_D1_BIT 29
`define UOE_EVEN_D0_BIT 28
`define UOE_SET_NAK_BIT 27
`define UOE_CLR_NAK_BIT 26
`define UOE_STALL_BIT 21
`define UOE_SNOOP_BIT 20
`define UOE_TYPE_HI 19
`define UOE_TYPE_LO 18
`define UOE_NAK_STAT_BIT 17
`define UOE_PAR_PID_BIT 16
`define UOE_ACTIVE_BIT 15
`define UOE_MPL_HI 10
`define UOE_MPL_LO 0

`endif

// ---- common/uoe_pkg.sv ----
// types shared by the out endpoint control block
package uoe_pkg;
	// endpoint transfer type encoding
	typedef enum logic [1:0] {
		UOE_TYPE_CONTROL = 2'h0,
		UOE_TYPE_ISO = 2'h1,
		UOE_TYPE_BULK = 2'h2,
		UOE_TYPE_INTR = 2'h3
	} uoe_type_e;

	// handshake answer to an out token
	typedef enum logic [2:0] {
		UOE_HS_NONE = 3'h0,
		UOE_HS_ACK = 3'h1,
		UOE_HS_NAK = 3'h2,
		UOE_HS_STALL = 3'h3,
		UOE_HS_DROP = 3'h4
	} uoe_hs_e;
endpackage

// ---- rtl/uoe_wb_slave.sv ----
// classic wishbone slave front end with one-cycle registered ack
`include "uoe_regs.svh"
module uoe_wb_slave (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// wishbone
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [31:0] i_rd_word,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// single-cycle accepted write
	output logic o_wr_pulse
);
	wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire hit = (i_wb_adr == `UOE_CTL_OFFSET);

	// write lands at the edge where the master samples ack high
	assign o_wr_pulse = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & hit;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else begin
			o_wb_ack <= req;
			// unmapped reads return zero
			o_wb_dat <= (req && hit && !i_wb_we) ? i_rd_word : 32'h00000000;
		end
	end
endmodule

// ---- rtl/uoe_endpoint.sv ----
// out endpoint control: register, handshake choice and toggle tracking
`include "uoe_regs.svh"
module uoe_endpoint
	import uoe_pkg::*;
#(
	parameter int MPL_W = 11
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// device-wide state
	input wire logic i_global_out_nak,
	input wire logic i_frame_odd,
	// token and packet events from the link layer
	input wire logic i_out_token,
	input wire logic i_setup_token,
	input wire logic i_data_rx,
	input wire logic i_data_pid,
	input wire logic i_crc_ok,
	input wire logic [MPL_W-1:0] i_data_len,
	input wire logic i_fifo_room,
	input wire logic i_xfer_done,
	// answers
	output uoe_hs_e o_handshake,
	output logic o_hs_valid,
	output logic o_data_accept,
	output logic o_toggle_ok,
	output logic o_enabled,
	output logic o_active
);
	// ****************************************************************
	// bus
	// ****************************************************************
	logic wr;
	logic [31:0] rd_word;
	uoe_wb_slave u_wb (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr),
		.i_rd_word(rd_word),
		.o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack),
		.o_wr_pulse(wr)
	);

	// byte lane gated write strobes
	wire wr3 = wr & i_wb_sel[3];
	wire wr2 = wr & i_wb_sel[2];
	wire wr1 = wr & i_wb_sel[1];
	wire wr0 = wr & i_wb_sel[0];
	wire set_nak = wr3 & i_wb_dat[`UOE_SET_NAK_BIT];
	wire clr_nak = wr3 & i_wb_dat[`UOE_CLR_NAK_BIT];
	wire req_hi = wr3 & i_wb_dat[`UOE_ODD_D1_BIT];
	wire req_lo = wr3 & i_wb_dat[`UOE_EVEN_D0_BIT];
	wire en_set = wr3 & i_wb_dat[`UOE_ENABLE_BIT];
	wire dis_req = wr3 & i_wb_dat[`UOE_DISABLE_BIT];

	// ****************************************************************
	// control register state
	// ****************************************************************
	logic enable;
	logic stall;
	logic snoop;
	uoe_type_e ep_type;
	logic nak_stat;
	logic par_pid;
	logic active;
	logic [MPL_W-1:0] max_packet_bytes;

	wire is_ctrl = (ep_type == UOE_TYPE_CONTROL);
	wire is_iso = (ep_type == UOE_TYPE_ISO);
	wire tog_type = (ep_type == UOE_TYPE_BULK) ||
		(ep_type == UOE_TYPE_INTR);

	// token answer decode
	wire tok = i_out_token & active;
	wire fifo_ok = i_fifo_room & ~nak_stat;
	wire crc_ok = i_crc_ok | snoop;
	wire len_ok = (i_data_len <= max_packet_bytes);
	wire par_ok = ~is_iso | (i_frame_odd == par_pid);
	wire pid_ok = ~tog_type | (i_data_pid == par_pid);
	wire pkt_good = i_data_rx & active & crc_ok & len_ok & par_ok;
	wire take = pkt_good & ~stall & ~i_global_out_nak & fifo_ok & enable;

	uoe_hs_e next_hs;
	always_comb begin
		next_hs = UOE_HS_NONE;
		if (tok || (i_data_rx && active)) begin
			if (stall)
				next_hs = UOE_HS_STALL;
			else if (i_global_out_nak || nak_stat || !i_fifo_room)
				next_hs = UOE_HS_NAK;
			else if (i_data_rx && !pkt_good)
				next_hs = UOE_HS_DROP;
			else if (i_data_rx)
				next_hs = UOE_HS_ACK;
		end
	end

	// stall clear: software on bulk/interrupt/iso, setup only on control
	wire sw_stall_wr = wr2;
	wire next_stall = (is_ctrl && i_setup_token && active) ? 1'b0 :
		(sw_stall_wr && i_wb_dat[`UOE_STALL_BIT]) ? 1'b1 :
		(sw_stall_wr && !is_ctrl) ? 1'b0 : stall;

	// nak status: set wins over clear
	wire next_nak = set_nak ? 1'b1 : (clr_nak ? 1'b0 : nak_stat);

	// parity or pid bit
	logic next_pp;
	always_comb begin
		next_pp = par_pid;
		if (take && tog_type && pid_ok)
			next_pp = ~par_pid;
		if (req_lo)
			next_pp = 1'b0;
		if (req_hi)
			next_pp = 1'b1;
	end

	// enable: device clears on disable request or transfer end
	wire next_en = en_set ? 1'b1 :
		((dis_req || i_xfer_done) ? 1'b0 : enable);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			enable <= 1'b0;
			stall <= 1'b0;
			nak_stat <= 1'b0;
			par_pid <= 1'b0;
		end else begin
			enable <= next_en;
			stall <= next_stall;
			nak_stat <= next_nak;
			par_pid <= next_pp;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			snoop <= 1'b0;
			ep_type <= UOE_TYPE_CONTROL;
			active <= 1'b0;
			max_packet_bytes <= '0;
		end else begin
			if (wr2) begin
				snoop <= i_wb_dat[`UOE_SNOOP_BIT];
				ep_type <= uoe_type_e'(i_wb_dat[`UOE_TYPE_HI:`UOE_TYPE_LO]);
			end
			if (wr1)
				active <= i_wb_dat[`UOE_ACTIVE_BIT];
			if (wr1 || wr0) begin
				max_packet_bytes[7:0] <= wr0 ? i_wb_dat[7:0] : max_packet_bytes[7:0];
				max_packet_bytes[MPL_W-1:8] <= wr1 ? i_wb_dat[MPL_W-1:8] : max_packet_bytes[MPL_W-1:8];
			end
		end
	end

	// readback: request strobes read zero
	always_comb begin
		rd_word = 32'h00000000;
		rd_word[`UOE_ENABLE_BIT] = enable;
		rd_word[`UOE_STALL_BIT] = stall;
		rd_word[`UOE_SNOOP_BIT] = snoop;
		rd_word[`UOE_TYPE_HI:`UOE_TYPE_LO] = ep_type;
		rd_word[`UOE_NAK_STAT_BIT] = nak_stat;
		rd_word[`UOE_PAR_PID_BIT] = par_pid;
		rd_word[`UOE_ACTIVE_BIT] = active;
		rd_word[`UOE_MPL_HI:`UOE_MPL_LO] = max_packet_bytes;
	end

	// ****************************************************************
	// registered answers
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_handshake <= UOE_HS_NONE;
			o_hs_valid <= 1'b0;
			o_data_accept <= 1'b0;
			o_toggle_ok <= 1'b0;
		end else begin
			o_handshake <= next_hs;
			o_hs_valid <= (next_hs != UOE_HS_NONE);
			o_data_accept <= take;
			o_toggle_ok <= take & pid_ok;
		end
	end

	assign o_enabled = enable;
	assign o_active = active;
endmodule

// ---- bench/uoe_host_model.sv ----
// usb host stand-in issuing out and setup token events
module uoe_host_model (
	// clock
	input wire logic i_clk,
	// token and packet events
	output logic o_out_token = 1'h0,
	output logic o_setup_token = 1'h0,
	output logic o_data_rx = 1'h0,
	// qualifiers, valid with o_data_rx only
	output logic o_pid = 1'h0,
	output logic o_crc = 1'h0,
	output logic [10:0] o_len = 11'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	// one out transaction, or a lone setup token when s is set
	task automatic xact(input logic s, input logic p, input logic c,
		input logic [10:0] n);
		o_out_token <= !s;
		o_setup_token <= s;
		o_data_rx <= !s;
		o_pid <= p;
		o_crc <= c;
		o_len <= n;
		@(posedge i_clk);
		o_out_token <= 1'h0;
		o_setup_token <= 1'h0;
		o_data_rx <= 1'h0;
		// stale qualifiers are not left on the lines
		o_pid <= !p;
		o_crc <= !c;
		o_len <= ~n;
		repeat (2) @(posedge i_clk);
	endtask
endmodule

// ---- bench/uoe_endpoint_chk.sv ----
// port assertions for the out endpoint control block
module uoe_endpoint_chk
	import uoe_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic i_out_token,
	input wire logic i_data_rx,
	input wire logic i_fifo_room,
	input wire logic i_global_out_nak,
	input wire logic i_xfer_done,
	input wire uoe_hs_e o_handshake,
	input wire logic o_hs_valid,
	input wire logic o_data_accept,
	input wire logic o_toggle_ok,
	input wire logic o_enabled,
	input wire logic o_active
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
	sequence s_tok; i_out_token && o_active; endsequence
	property p_ack; s_req |=> o_wb_ack ##1 !o_wb_ack; endproperty
	property p_off; i_out_token && !o_active |=>
		o_handshake == UOE_HS_NONE && !o_hs_valid; endproperty
	property p_ans; s_tok |=> o_hs_valid; endproperty
	property p_gnak; s_tok and i_global_out_nak |=>
		o_handshake inside {UOE_HS_NAK, UOE_HS_STALL}; endproperty
	property p_room; i_data_rx && o_active && !i_fifo_room |=>
		o_handshake != UOE_HS_ACK && !o_data_accept; endproperty
	property p_acc; o_data_accept |-> $past(i_data_rx) && $past(o_active);
	endproperty
	property p_tog; o_toggle_ok |-> o_data_accept; endproperty
	property p_rdz; o_wb_ack |-> o_wb_dat[29:26] == 4'h0; endproperty
	property p_xfer; i_xfer_done |=> !o_enabled; endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	a_off: assert property (p_off) else $error("inactive answer");
	a_ans: assert property (p_ans) else $error("no answer");
	a_gnak: assert property (p_gnak) else $error("gnak");
	a_room: assert property (p_room) else $error("no room");
	a_acc: assert property (p_acc) else $error("accept");
	a_tog: assert property (p_tog) else $error("toggle");
	a_rdz: assert property (p_rdz) else $error("strobe read");
	a_xfer: assert property (p_xfer) else $error("enable");
endmodule
bind uoe_endpoint uoe_endpoint_chk u_chk (.i_clk, .i_arst_n, .i_wb_cyc,
	.i_wb_stb, .o_wb_dat, .o_wb_ack, .i_out_token, .i_data_rx, .i_fifo_room,
	.i_global_out_nak, .i_xfer_done, .o_handshake, .o_hs_valid,
	.o_data_accept, .o_toggle_ok, .o_enabled, .o_active);

// ---- bench/testbench.sv ----
// self-checking bench for the out endpoint control block
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin \
	err_total++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench
	import uoe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_arst_n = 0, cyc = 0, stb = 0, we = 0, gnak = 0;
	logic fodd = 0, room = 1, xd = 0, tok, stok, drx, pid, crc, o_wb_ack;
	logic o_hs_valid;
	logic [3:0] adr = 0;
	logic [31:0] dat = 0, o_wb_dat, b, c, er;
	logic [10:0] m, len;
	uoe_hs_e o_handshake, eh;
	uoe_hs_e hq[$];
	logic [31:0] rq[$];
	int err_total = 0, checks_done = 0, seed = 32'hA0AA0CB5;
	always #5 i_clk = !i_clk;
	uoe_host_model u_uoe_host_model (.i_clk, .o_out_token(tok),
		.o_setup_token(stok), .o_data_rx(drx), .o_pid(pid), .o_crc(crc),
		.o_len(len));
	uoe_endpoint #(.MPL_W(11)) u_uoe_endpoint (.i_clk, .i_arst_n,
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat, .o_wb_ack,
		.i_global_out_nak(gnak), .i_frame_odd(fodd), .i_out_token(tok),
		.i_setup_token(stok), .i_data_rx(drx), .i_data_pid(pid),
		.i_crc_ok(crc), .i_data_len(len), .i_fifo_room(room),
		.i_xfer_done(xd), .o_handshake, .o_hs_valid, .o_data_accept(),
		.o_toggle_ok(), .o_enabled(), .o_active());
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'h1 && n < 20);
		if (n == 20) begin
			err_total++;
			complete_run();
		end
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [31:0] d); wb(1, 0, d); endtask
	task automatic rd(input logic [31:0] e);
		rq.push_back(e);
		wb(0, 0, 0);
	endtask
	task automatic ox(input logic p, c, input logic [10:0] n, input uoe_hs_e e);
		if (e != UOE_HS_NONE) hq.push_back(e);
		u_uoe_host_model.xact(0, p, c, n);
	endtask
	always @(posedge i_clk) begin
		if (o_hs_valid === 1'h1 && hq.size() > 0) begin
			eh = hq.pop_front();
			`CHK("handshake", eh, o_handshake)
		end
		if (o_wb_ack === 1'h1 && we === 1'h0 && rq.size() > 0) begin
			er = rq.pop_front();
			`CHK("read", er, o_wb_dat)
		end
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'h1;
		m = 11'(8 + ($random(seed) & 63));
		b = 32'h00088000 | m;
		c = 32'h00008000 | m;
		rd(0);
		rq.push_back(0);
		wb(0, 4'h5, 0);
		for (int t = 0; t < 4; t++) begin
			wr(t << 18);
			rd(t << 18);
		end
		wr(b | 32'h08000000);
		rd(b | 32'h00020000);
		ox(0, 1, m, UOE_HS_NAK);
		wr(b | 32'h04020000);
		rd(b);
		wr(b | 32'h80000000);
		rd(b | 32'h80000000);
		xd <= 1'h1;
		@(posedge i_clk);
		xd <= 1'h0;
		rd(b);
		$display("test register done");
		wr(b | 32'h90000000);
		ox(0, 1, m, UOE_HS_ACK);
		rd(b | 32'h80010000);
		ox(1, 1, m + 11'h1, UOE_HS_DROP);
		ox(1, 0, m, UOE_HS_DROP);
		room <= 1'h0;
		ox(1, 1, m, UOE_HS_NAK);
		room <= 1'h1;
		wr(b | 32'h20100000);
		ox(1, 0, m, UOE_HS_ACK);
		$display("test data done");
		wr(b | 32'h08200000);
		ox(1, 1, m, UOE_HS_STALL);
		gnak <= 1'h1;
		ox(1, 1, m, UOE_HS_STALL);
		u_uoe_host_model.xact(1, 0, 0, 0);
		ox(1, 1, m, UOE_HS_STALL);
		wr(b | 32'h04000000);
		ox(1, 1, m, UOE_HS_NAK);
		gnak <= 1'h0;
		wr(c | 32'h00200000);
		wr(c);
		ox(0, 1, m, UOE_HS_STALL);
		u_uoe_host_model.xact(1, 0, 0, 0);
		ox(0, 1, m, UOE_HS_ACK);
		$display("test stall done");
		wr(32'h20048000 | m);
		rd(32'h80058000 | m);
		ox(0, 1, m, UOE_HS_DROP);
		fodd <= 1'h1;
		ox(0, 1, m, UOE_HS_ACK);
		wr(32'h10048000 | m);
		rd(32'h80048000 | m);
		wr(32'h00080000 | m);
		ox(0, 1, m, UOE_HS_NONE);
		`CHK("pending", 0, hq.size() + rq.size())
		$display("test iso done");
		complete_run();
	end
endmodule
